// >>> design/eth_csr_decoder.sv
// Address decoder for the Ethernet configuration and status space.
// Assumes initiators hold a request until granted and accept the answer one cycle later.
//
// Overview of operation
// RULE_01: Accept 42-bit byte address per access.
// RULE_02: Top eight bits must equal 00100000.
// RULE_03: Bits 33 to 28 pick the subsystem.
// RULE_04: 011011 is subsystem zero, 011100 is one.
// RULE_05: Bits 27 to 24 pick the block.
// RULE_06: Codes 0-3: control, shared PCS, quad PCSs.
// RULE_07: Codes 4-9: big MACs, quad MACs, SerDes.
// RULE_08: System control holds clock and reset selection.
// RULE_09: Both quad MACs share one register layout.
// RULE_10: Four register copies per quad, one per channel.
// RULE_11: Revision is 32-bit read-only.
// RULE_12: Scratch is 32-bit read-write, resets to zero.
// RULE_13: PCIe, JTAG and fabric share one decode.
// RULE_14: Bits 23 to 0 are the byte offset.
// RULE_15: Unmatched accesses modify no register.
`timescale 1ns/10ps
module eth_csr_decoder #(
  parameter logic [31:0] REVISION = 32'h0000_0001  // Value is arbitrary.
) (
  // Clock and reset
  input  wire logic                                            i_clk,
  input  wire logic                                            i_rst,
  // Initiator requests, index 0 PCIe, 1 JTAG, 2 fabric
  input  wire eth_csr_pkg::req_t [eth_csr_pkg::N_INIT-1:0]     i_req,
  output logic                   [eth_csr_pkg::N_INIT-1:0]     o_grant,
  // Answer to the granted initiator
  output eth_csr_pkg::rsp_t                                    o_rsp,
  // Access passed on to the PCS, big MAC and SerDes maps
  output eth_csr_pkg::fwd_t                                    o_fwd,
  // Clock and reset source selection, one word per subsystem
  output logic                   [1:0][eth_csr_pkg::DATA_W-1:0] o_clk_rst_sel
);

  typedef struct packed {
    eth_csr_pkg::rsp_t                      rsp;
    eth_csr_pkg::fwd_t                      fwd;
    logic [1:0][eth_csr_pkg::DATA_W-1:0]    clkrst;
  } state_t;

  state_t                                   state_q;
  state_t                                   state_d;
  eth_csr_pkg::req_t                        req;
  logic                                     any;
  logic [1:0]                               src;
  logic                                     space_ok;
  logic                                     tgt_ok;
  logic                                     subsys;
  logic [3:0]                               blk;
  logic [eth_csr_pkg::OFS_W-1:0]            offset;
  logic                                     blk_fwd;
  logic [3:0]                               qsel;
  wire logic [3:0]                          qhit;
  wire logic [3:0][eth_csr_pkg::DATA_W-1:0] qrdata;
  logic [1:0]                               qidx;

  ////////////////////////////////////////////////////////////////////////////
  // Fixed priority between initiators. A lower one simply waits, which keeps the
  // decode identical for all of them and costs only latency under contention.
  always_comb begin
    o_grant = '0;
    any     = 1'b0;
    src     = eth_csr_pkg::INIT_PCIE;
    req     = '0;
    for (int k = eth_csr_pkg::N_INIT - 1; k >= 0; k--) begin
      if (i_req[k].valid) begin
        o_grant = '0;
        o_grant[k] = 1'b1;  // [RULE_13]
        any     = 1'b1;
        src     = 2'(k);
        req     = i_req[k];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Field decode of the winning address.
  always_comb begin
    space_ok = (req.addr[eth_csr_pkg::SPACE_MSB:eth_csr_pkg::SPACE_LSB] == eth_csr_pkg::SPACE_CSR);  // [RULE_02]
    tgt_ok   = (req.addr[eth_csr_pkg::TGT_MSB:eth_csr_pkg::TGT_LSB] == eth_csr_pkg::TGT_ETH0) ||
               (req.addr[eth_csr_pkg::TGT_MSB:eth_csr_pkg::TGT_LSB] == eth_csr_pkg::TGT_ETH1);  // [RULE_03] [RULE_04]
    subsys   = (req.addr[eth_csr_pkg::TGT_MSB:eth_csr_pkg::TGT_LSB] == eth_csr_pkg::TGT_ETH1);  // [RULE_04]
    blk      = req.addr[eth_csr_pkg::BLK_MSB:eth_csr_pkg::BLK_LSB];  // [RULE_05]
    offset   = req.addr[eth_csr_pkg::OFS_W-1:0];  // [RULE_01] [RULE_14]
    case (blk)
      eth_csr_pkg::BLK_PCS_BIG,
      eth_csr_pkg::BLK_PCS_Q0,
      eth_csr_pkg::BLK_PCS_Q1: begin
        blk_fwd = 1'b1;  // [RULE_06]
      end
      eth_csr_pkg::BLK_MAC_B0,
      eth_csr_pkg::BLK_MAC_B1,
      eth_csr_pkg::BLK_SERDES0,
      eth_csr_pkg::BLK_SERDES1: begin
        blk_fwd = 1'b1;  // [RULE_07]
      end
      default: begin
        blk_fwd = 1'b0;
      end
    endcase
    qidx = {subsys, (blk == eth_csr_pkg::BLK_QMAC1)};
    qsel = '0;
    if (any && space_ok && tgt_ok &&
        ((blk == eth_csr_pkg::BLK_QMAC0) || (blk == eth_csr_pkg::BLK_QMAC1))) begin
      qsel[qidx] = 1'b1;  // [RULE_07] [RULE_15]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // One register set per quad; the same module keeps both quads alike.
  for (genvar g = 0; g < 4; g++) begin : g_quad
    quad_mac_regs #(
      .REVISION (REVISION)
    ) u_regs (
      .i_clk    (i_clk),
      .i_rst    (i_rst),
      .i_sel    (qsel[g]),
      .i_write  (req.write),
      .i_offset (offset),
      .i_wdata  (req.wdata),
      .o_hit    (qhit[g]),
      .o_rdata  (qrdata[g])
    );  // [RULE_09] [RULE_10]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state: answer, forward strobe and system control words.
  always_comb begin
    state_d           = state_q;
    state_d.rsp       = '0;
    state_d.fwd       = '0;
    state_d.rsp.valid = any;
    state_d.rsp.src   = src;
    if (any && space_ok && tgt_ok) begin
      if (blk == eth_csr_pkg::BLK_SYSCTL) begin
        if (offset == eth_csr_pkg::REG_CLKRST) begin
          state_d.rsp.hit   = 1'b1;
          state_d.rsp.rdata = state_q.clkrst[subsys];  // [RULE_08]
          if (req.write) begin
            state_d.clkrst[subsys] = req.wdata;  // [RULE_08]
          end
        end
      end else if (blk_fwd) begin
        state_d.rsp.hit    = 1'b1;
        state_d.fwd.valid  = 1'b1;
        state_d.fwd.write  = req.write;
        state_d.fwd.subsys = subsys;
        state_d.fwd.block  = blk;
        state_d.fwd.offset = offset;  // [RULE_14]
        state_d.fwd.wdata  = req.wdata;
      end else if (|(qsel & qhit)) begin
        state_d.rsp.hit   = 1'b1;
        state_d.rsp.rdata = qrdata[qidx];  // [RULE_11] [RULE_12]
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_q.rsp    <= '0;
      state_q.fwd    <= '0;
      state_q.clkrst <= {2{eth_csr_pkg::CLKRST_RST}};
    end else begin
      state_q <= state_d;
    end
  end

  assign o_rsp         = state_q.rsp;
  assign o_fwd         = state_q.fwd;
  assign o_clk_rst_sel = state_q.clkrst;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  grant_onehot_a: assert property (@(posedge i_clk) disable iff (i_rst)  // [RULE_13]
    $onehot0(o_grant) && (any == (|o_grant)))
    else $error("Grant is not one-hot.");

  rsp_latency_a: assert property (@(posedge i_clk) disable iff (i_rst)  // [RULE_13]
    (|o_grant) |=> (o_rsp.valid && (o_rsp.src == $past(src))))
    else $error("Answer missing one cycle after grant.");

  space_reject_a: assert property (@(posedge i_clk) disable iff (i_rst)  // [RULE_02]
    (any && !space_ok) |=> (!o_rsp.hit && !o_fwd.valid))
    else $error("Access outside the register space was answered as a hit.");

  tgt_reject_a: assert property (@(posedge i_clk) disable iff (i_rst)  // [RULE_04]
    (any && !tgt_ok) |=> (!o_rsp.hit && !o_fwd.valid))
    else $error("Unknown subsystem target was answered as a hit.");

  unmapped_nowrite_a: assert property (@(posedge i_clk) disable iff (i_rst)  // [RULE_15]
    (any && !(space_ok && tgt_ok)) |=> $stable(o_clk_rst_sel))
    else $error("Unmatched access changed a control word.");

  clkrst_write_a: assert property (@(posedge i_clk) disable iff (i_rst)  // [RULE_08]
    (any && space_ok && tgt_ok && req.write && (blk == eth_csr_pkg::BLK_SYSCTL) &&
     (offset == eth_csr_pkg::REG_CLKRST))
    |=> (o_clk_rst_sel[$past(subsys)] == $past(req.wdata)))
    else $error("Clock and reset selection did not take the write.");

  fwd_block_a: assert property (@(posedge i_clk) disable iff (i_rst)  // [RULE_07]
    (any && space_ok && tgt_ok && blk_fwd)
    |=> (o_fwd.valid && (o_fwd.block == $past(blk)) && (o_fwd.subsys == $past(subsys))))
    else $error("Forwarded block or subsystem is wrong.");

  fwd_offset_a: assert property (@(posedge i_clk) disable iff (i_rst)  // [RULE_14]
    o_fwd.valid |-> (o_fwd.offset == $past(offset)))
    else $error("Forwarded offset is not the low address bits.");

endmodule // eth_csr_decoder

// >>> design/eth_csr_pkg.sv
// Shared constants and carrier types for the Ethernet register-space decoder.
// Assumes one clock and a synchronous active-high reset in every user.
package eth_csr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Address layout.
  localparam int          ADDR_W     = 42;
  localparam int          DATA_W     = 32;
  localparam int          N_INIT     = 3;
  localparam int          SPACE_MSB  = 41;
  localparam int          SPACE_LSB  = 34;
  localparam int          TGT_MSB    = 33;
  localparam int          TGT_LSB    = 28;
  localparam int          BLK_MSB    = 27;
  localparam int          BLK_LSB    = 24;
  localparam int          OFS_W      = 24;
  localparam logic [7:0]  SPACE_CSR  = 8'h20;
  localparam logic [5:0]  TGT_ETH0   = 6'h1B;
  localparam logic [5:0]  TGT_ETH1   = 6'h1C;

  ////////////////////////////////////////////////////////////////////////////
  // Initiator indices, highest priority first.
  localparam logic [1:0]  INIT_PCIE  = 2'h0;
  localparam logic [1:0]  INIT_JTAG  = 2'h1;
  localparam logic [1:0]  INIT_AXI   = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Block-select codes inside one subsystem.
  typedef enum logic [3:0] {
    BLK_SYSCTL  = 4'h0,
    BLK_PCS_BIG = 4'h1,
    BLK_PCS_Q0  = 4'h2,
    BLK_PCS_Q1  = 4'h3,
    BLK_MAC_B0  = 4'h4,
    BLK_MAC_B1  = 4'h5,
    BLK_QMAC0   = 4'h6,
    BLK_QMAC1   = 4'h7,
    BLK_SERDES0 = 4'h8,
    BLK_SERDES1 = 4'h9
  } blk_t;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets and reset values.
  localparam logic [23:0] REG_REVISION  = 24'h00_0000;
  localparam logic [23:0] REG_SCRATCH   = 24'h00_0004;
  localparam logic [23:0] REG_CLKRST    = 24'h00_0000;
  localparam logic [31:0] SCRATCH_RST   = 32'h0000_0000;
  localparam logic [31:0] CLKRST_RST    = 32'h0000_0000;
  localparam int          CHAN_LSB      = 12;
  localparam int          CHAN_W        = 2;
  localparam int          N_CHAN        = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers.
  typedef struct packed {
    logic              valid;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } req_t;

  typedef struct packed {
    logic              valid;
    logic              hit;
    logic [1:0]        src;
    logic [DATA_W-1:0] rdata;
  } rsp_t;

  typedef struct packed {
    logic              valid;
    logic              write;
    logic              subsys;
    logic [3:0]        block;
    logic [OFS_W-1:0]  offset;
    logic [DATA_W-1:0] wdata;
  } fwd_t;

endpackage

// >>> design/quad_mac_regs.sv
// Revision and scratch registers of one four-channel MAC, one copy per channel.
// Assumes the parent presents a single-cycle access strobe with a decoded offset.
`timescale 1ns/10ps
module quad_mac_regs #(
  parameter logic [31:0] REVISION = 32'h0000_0001  // Value is arbitrary.
) (
  // Clock and reset
  input  wire logic                              i_clk,
  input  wire logic                              i_rst,
  // Access
  input  wire logic                              i_sel,
  input  wire logic                              i_write,
  input  wire logic [eth_csr_pkg::OFS_W-1:0]     i_offset,
  input  wire logic [eth_csr_pkg::DATA_W-1:0]    i_wdata,
  // Answer
  output logic                                   o_hit,
  output logic      [eth_csr_pkg::DATA_W-1:0]    o_rdata
);

  typedef struct packed {
    logic [eth_csr_pkg::N_CHAN-1:0][eth_csr_pkg::DATA_W-1:0] scratch;
  } state_t;

  state_t                               state_q;
  state_t                               state_d;
  logic [eth_csr_pkg::CHAN_W-1:0]       chan;
  logic [eth_csr_pkg::OFS_W-1:0]        reg_ofs;
  logic                                 is_rev;
  logic                                 is_scr;

  ////////////////////////////////////////////////////////////////////////////
  // Channel number sits above the register offset, so every channel sees the same layout.
  always_comb begin
    chan    = i_offset[eth_csr_pkg::CHAN_LSB +: eth_csr_pkg::CHAN_W];
    reg_ofs = i_offset;
    reg_ofs[eth_csr_pkg::CHAN_LSB +: eth_csr_pkg::CHAN_W] = '0;  // [RULE_10]
    is_rev  = (reg_ofs == eth_csr_pkg::REG_REVISION);
    is_scr  = (reg_ofs == eth_csr_pkg::REG_SCRATCH);
    o_hit   = is_rev || is_scr;
    o_rdata = is_rev ? REVISION : (is_scr ? state_q.scratch[chan] : '0);  // [RULE_11] [RULE_12]
  end

  always_comb begin
    state_d = state_q;
    if (i_sel && i_write && is_scr) begin
      state_d.scratch[chan] = i_wdata;  // [RULE_12]
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_q.scratch <= {eth_csr_pkg::N_CHAN{eth_csr_pkg::SCRATCH_RST}};  // [RULE_12]
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  revision_ro_a: assert property (@(posedge i_clk) disable iff (i_rst)  // [RULE_11]
    (i_sel && i_write && is_rev) |=> $stable(state_q.scratch))
    else $error("Write to revision changed a scratch register.");

  scratch_keep_a: assert property (@(posedge i_clk) disable iff (i_rst)  // [RULE_12]
    (i_sel && i_write && is_scr) |=> (state_q.scratch[$past(chan)] == $past(i_wdata)))
    else $error("Scratch did not take the written value.");

  revision_val_a: assert property (@(posedge i_clk) disable iff (i_rst)  // [RULE_11]
    (is_rev |-> (o_rdata == REVISION)))
    else $error("Revision read returned a wrong value.");

endmodule // quad_mac_regs

// >>> verif/initiator_model.sv
// Behavioural bus initiator standing in for a host-side master of the decoder.
// Assumes a combinational grant and an answer one cycle after the taking edge.
`timescale 1ns/10ps
module initiator_model #(
  parameter logic [1:0] IDX = 2'h0
) (
  // Clock and reset
  input  wire logic                          i_clk,
  input  wire logic                          i_rst,
  // Command from the bench
  input  wire logic                          i_go,
  input  wire eth_csr_pkg::req_t             i_cmd,
  // Decoder side
  input  wire logic                          i_grant,
  input  wire eth_csr_pkg::rsp_t             i_rsp,
  output eth_csr_pkg::req_t                  o_req,
  // Result to the bench
  output logic                               o_done,
  output logic                               o_hit,
  output logic [eth_csr_pkg::DATA_W-1:0]     o_rdata
);
  ////////////////////////////////////////////////////////////////////////////
  logic wait_q;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_req   <= '0;
      wait_q  <= 1'b0;
      o_done  <= 1'b0;
      o_hit   <= 1'b0;
      o_rdata <= '0;
    end else begin
      o_done <= wait_q && i_rsp.valid && (i_rsp.src == IDX);
      if (wait_q && i_rsp.valid && i_rsp.src == IDX) begin
        o_hit   <= i_rsp.hit;
        o_rdata <= i_rsp.rdata;
        wait_q  <= 1'b0;
      end
      if (o_req.valid && i_grant) begin
        // Released lines are scrambled so the decoder cannot lean on stale values.
        o_req.valid <= 1'b0;
        o_req.write <= ~o_req.write;
        o_req.addr  <= ~o_req.addr;
        o_req.wdata <= ~o_req.wdata;
        wait_q      <= 1'b1;
      end else if (i_go && !o_req.valid && !wait_q) begin
        o_req <= '{valid: 1'b1, write: i_cmd.write, addr: i_cmd.addr, wdata: i_cmd.wdata};
      end
    end
  end
endmodule  // initiator_model

// >>> verif/ethernet_csr_address_decoder_tb.sv
// Self-checking bench for the Ethernet register-space decoder.
// Assumes three initiator models on the request ports and a 50 MHz clock.
`timescale 1ns/10ps
module ethernet_csr_address_decoder_tb;
  localparam logic [31:0] REV = 32'h0000_00A5;  // Value is arbitrary.

  logic                        i_clk = 1'b0;
  logic                        i_rst = 1'b1;
  logic [2:0]                  go = 3'h0;
  eth_csr_pkg::req_t [2:0]     cmd = '0;
  wire eth_csr_pkg::req_t [2:0] req;
  logic [2:0]                  grant;
  eth_csr_pkg::rsp_t           rsp;
  eth_csr_pkg::fwd_t           fwd;
  eth_csr_pkg::fwd_t           fwd_q;
  logic [1:0][31:0]            crs;
  wire logic [2:0]             done;
  wire logic [2:0]             hit;
  wire logic [2:0][31:0]       rdata;
  int                          num_errors = 0;
  int                          checks_done = 0;
  int                          fwd_n = 0;
  int                          cyc = 0;
  int                          stamp[3];

  always #10 i_clk = ~i_clk;

  eth_csr_decoder #(.REVISION(REV)) dut (.i_clk(i_clk), .i_rst(i_rst), .i_req(req), .o_grant(grant),
    .o_rsp(rsp), .o_fwd(fwd), .o_clk_rst_sel(crs));

  for (genvar k = 0; k < 3; k++) begin : g_init
    initiator_model #(.IDX(2'(k))) u_init (.i_clk(i_clk), .i_rst(i_rst), .i_go(go[k]), .i_cmd(cmd[k]),
      .i_grant(grant[k]), .i_rsp(rsp), .o_req(req[k]), .o_done(done[k]), .o_hit(hit[k]),
      .o_rdata(rdata[k]));
  end

  always @(posedge i_clk) begin
    cyc++;
    if (fwd.valid === 1'b1) begin
      fwd_n++;
      fwd_q = fwd;
    end
    for (int k = 0; k < 3; k++) if (done[k] === 1'b1) stamp[k] = cyc;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    if (num_errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask

  function automatic logic [41:0] ad(input logic s, input logic [3:0] b, input logic [23:0] o);
    ad = {eth_csr_pkg::SPACE_CSR, s ? eth_csr_pkg::TGT_ETH1 : eth_csr_pkg::TGT_ETH0, b, o};
  endfunction

  function automatic logic [41:0] qa(input logic s, input logic q, input logic [1:0] c, input logic [23:0] r);
    qa = ad(s, q ? eth_csr_pkg::BLK_QMAC1 : eth_csr_pkg::BLK_QMAC0, r | (24'(c) << eth_csr_pkg::CHAN_LSB));
  endfunction

  function automatic logic [31:0] val(input logic s, input logic q, input logic [1:0] c);
    val = {8'hC3, 7'h0, s, 7'h0, q, 6'h0, c};
  endfunction

  task automatic acc(input int k, input logic wr, input logic [41:0] a, input logic [31:0] wd);
    int n;
    fwd_n = 0;
    @(posedge i_clk);
    go[k] <= 1'b1;
    cmd[k] <= '{valid: 1'b0, write: wr, addr: a, wdata: wd};
    @(posedge i_clk);
    go[k] <= 1'b0;
    for (n = 0; n < 20; n++) begin
      @(posedge i_clk);
      #1;
      if (done[k] === 1'b1) break;
    end
    if (n == 20) begin
      num_errors++;
      $display("Error at %0t: no answer", $time);
      tally_and_finish();
    end
  endtask

  task automatic rd(input int k, input logic [41:0] a, input logic h, input logic [31:0] d);
    acc(k, 1'b0, a, 32'h0);
    chk_bit(hit[k], h);
    chk_word(rdata[k], d);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_vals();
    chk_word(crs[0] | crs[1], eth_csr_pkg::CLKRST_RST);
    for (int i = 0; i < 16; i++) rd(i % 3, qa(i[3], i[2], i[1:0], eth_csr_pkg::REG_SCRATCH), 1'b1, 32'h0);
  endtask

  task automatic t_scratch();
    for (int i = 0; i < 16; i++) acc(0, 1'b1, qa(i[3], i[2], i[1:0], eth_csr_pkg::REG_SCRATCH), val(i[3], i[2], i[1:0]));
    for (int i = 0; i < 16; i++) rd(1, qa(i[3], i[2], i[1:0], eth_csr_pkg::REG_SCRATCH), 1'b1, val(i[3], i[2], i[1:0]));
    acc(2, 1'b1, qa(1'b0, 1'b1, 2'h2, eth_csr_pkg::REG_REVISION), 32'hFFFF_FFFF);
    chk_bit(hit[2], 1'b1);
    rd(2, qa(1'b0, 1'b1, 2'h2, eth_csr_pkg::REG_SCRATCH), 1'b1, val(1'b0, 1'b1, 2'h2));
    for (int i = 0; i < 16; i++) rd(2, qa(i[3], i[2], i[1:0], eth_csr_pkg::REG_REVISION), 1'b1, REV);
  endtask

  task automatic t_blocks();
    logic e;
    for (int b = 0; b < 16; b++) begin
      e = b inside {1, 2, 3, 4, 5, 8, 9};
      acc(1, 1'b1, ad(1'b1, 4'(b), 24'h00_0010), 32'h1234_5678);
      chk_bit(hit[1], e);
      chk_word(32'(fwd_n), {31'h0, e});
      if (e) begin
        chk_word({fwd_q.write, fwd_q.subsys, fwd_q.block, fwd_q.offset}, {2'h3, 4'(b), 24'h00_0010});
        chk_word(fwd_q.wdata, 32'h1234_5678);
      end
    end
    chk_word(crs[1], 32'h0);
  endtask

  task automatic t_sysctl();
    acc(2, 1'b1, ad(1'b1, eth_csr_pkg::BLK_SYSCTL, eth_csr_pkg::REG_CLKRST), 32'h0000_00F3);
    chk_word(crs[1], 32'h0000_00F3);
    chk_word(crs[0], 32'h0);
    rd(1, ad(1'b1, eth_csr_pkg::BLK_SYSCTL, eth_csr_pkg::REG_CLKRST), 1'b1, 32'h0000_00F3);
  endtask

  task automatic t_mismatch();
    logic [41:0] bad[5];
    // Each address would alias scratch channel zero if a field were ignored.
    bad = '{{8'h21, eth_csr_pkg::TGT_ETH0, 4'h6, 24'h00_0004}, {8'h20, 6'h1D, 4'h6, 24'h00_0004},
            {8'h20, 6'h1A, 4'h6, 24'h00_0004}, qa(1'b0, 1'b0, 2'h0, 24'h00_0005),
            qa(1'b0, 1'b0, 2'h0, 24'h00_4004)};
    for (int i = 0; i < 5; i++) begin
      acc(0, 1'b1, bad[i], 32'hDEAD_BEEF);
      chk_bit(hit[0], 1'b0);
      chk_word(32'(fwd_n), 32'h0);
    end
    rd(0, qa(1'b0, 1'b0, 2'h0, eth_csr_pkg::REG_SCRATCH), 1'b1, val(1'b0, 1'b0, 2'h0));
  endtask

  task automatic t_prio();
    int n;
    stamp = '{-1, -1, -1};
    @(posedge i_clk);
    go <= 3'h7;
    for (int k = 0; k < 3; k++) cmd[k] <= '{1'b0, 1'b0, qa(1'b1, 1'b1, 2'h3, eth_csr_pkg::REG_SCRATCH), 32'h0};
    @(posedge i_clk);
    go <= 3'h0;
    for (n = 0; n < 20 && stamp[2] < 0; n++) @(posedge i_clk);
    #1;
    if (stamp[2] < 0) begin
      num_errors++;
      $display("Error at %0t: priority answers missing", $time);
      tally_and_finish();
    end
    chk_word(32'(stamp[1] - stamp[0]), 32'h1);
    chk_word(32'(stamp[2] - stamp[1]), 32'h1);
    for (int k = 0; k < 3; k++) chk_word(rdata[k], val(1'b1, 1'b1, 2'h3));
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge i_clk);
    i_rst <= 1'b0;
    t_reset_vals();
    t_scratch();
    t_blocks();
    t_sysctl();
    t_mismatch();
    t_prio();
    tally_and_finish();
  end
endmodule  // ethernet_csr_address_decoder_tb
